// ---- src/ppc_pkg.sv ----
// Constants, types and register map of the port pin crossbar configuration block.
// Assumes a single 10 MHz system clock and software access over AXI4-Lite.
package ppc_pkg;

  // Geometry
  localparam int NPINS = 16;                      // Two ports of eight pins
  localparam int NFUNC = 8;                       // Routable peripheral signals
  localparam int FW    = 3;                       // Width of a function index

  // Register byte offsets
  localparam logic [7:0] OFS_INPUT_MODE  = 8'h00; // port_input_mode_bits
  localparam logic [7:0] OFS_OUTPUT_MODE = 8'h04; // port_output_mode_bits
  localparam logic [7:0] OFS_SKIP        = 8'h08; // crossbar_skip_bits
  localparam logic [7:0] OFS_LATCH       = 8'h0C; // port_latch
  localparam logic [7:0] OFS_ASSIGN_A    = 8'h10; // crossbar_assign_reg_a
  localparam logic [7:0] OFS_ASSIGN_B    = 8'h14; // crossbar_assign_reg_b
  localparam logic [7:0] OFS_PIN_STATE   = 8'h18; // Read-only digital pin levels

  // Reset values
  localparam logic [15:0] RST_INPUT_MODE  = 16'hFFFF; // All digital
  localparam logic [15:0] RST_OUTPUT_MODE = 16'h0000; // All open-drain
  localparam logic [15:0] RST_SKIP        = 16'h0000;
  localparam logic [15:0] RST_LATCH       = 16'hFFFF;
  localparam logic [7:0]  RST_ASSIGN_A    = 8'h00;
  localparam logic [7:0]  RST_ASSIGN_B    = 8'h00;

  // Fields of crossbar_assign_reg_a: peripheral enables
  localparam int BIT_UART_EN = 0;                 // Functions 0,1
  localparam int BIT_SPI_EN  = 1;                 // Functions 2..5
  localparam int BIT_SMB_EN  = 2;                 // Functions 6,7
  // Fields of crossbar_assign_reg_b
  localparam int BIT_XBAR_EN = 6;                 // crossbar_enable_bit
  localparam int BIT_WPUD    = 7;                 // weak_pullup_disable

  // Functions in crossbar priority order
  typedef enum logic [2:0] {
    PPC_F_UART_TX  = 3'h0,
    PPC_F_UART_RX  = 3'h1,
    PPC_F_SPI_SCK  = 3'h2,
    PPC_F_SPI_MISO = 3'h3,
    PPC_F_SPI_MOSI = 3'h4,
    PPC_F_SPI_NSS  = 3'h5,
    PPC_F_SMB_SDA  = 3'h6,
    PPC_F_SMB_SCL  = 3'h7
  } ppc_func_t;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- src/ppc_map_if.sv ----
// Pin-to-function map carried from the crossbar decoder to the pad logic.
// Assumes both ends run on the same clock; the map is combinational.
`timescale 1ns/100ps
interface ppc_map_if;
  logic [ppc_pkg::NPINS-1:0]       pin_assigned;  // Pin carries a peripheral
  logic [ppc_pkg::NPINS*ppc_pkg::FW-1:0] pin_func; // Function index per pin
  modport xbar (output pin_assigned, output pin_func);
  modport pad  (input  pin_assigned, input  pin_func);
endinterface

// ---- src/ppc_xbar.sv ----
// Crossbar priority decoder: hands enabled functions to the lowest free pins.
// Assumes skip bits and enables are stable register outputs.
`timescale 1ns/100ps
module ppc_xbar (
  // Configuration
  input  wire logic [ppc_pkg::NFUNC-1:0] func_en,
  input  wire logic [ppc_pkg::NPINS-1:0] skip,
  input  wire logic                      xbar_en,
  // Map out
  ppc_map_if.xbar                        map
);

  logic [ppc_pkg::NPINS-1:0]          taken;   // Pins already handed out
  logic [ppc_pkg::NPINS*ppc_pkg::FW-1:0] funcs;
  logic                               placed;  // Current function found a pin

  // Walk functions in priority order, each takes the first free pin
  always_comb begin
    taken  = '0;
    funcs  = '0;
    placed = 1'b0;
    for (int f = 0; f < ppc_pkg::NFUNC; f++) begin
      placed = 1'b0;
      for (int p = 0; p < ppc_pkg::NPINS; p++) begin
        if (xbar_en && func_en[f] && !placed && !skip[p] && !taken[p]) begin
          taken[p]                       = 1'b1;
          funcs[p*ppc_pkg::FW +: ppc_pkg::FW] = f[ppc_pkg::FW-1:0];
          placed                         = 1'b1;
        end
      end
    end
  end

  // Nothing is assigned while the crossbar is off
  assign map.pin_assigned = taken;
  assign map.pin_func     = funcs;

endmodule // ppc_xbar

// ---- src/ppc_pad.sv ----
// Per-pin driver, pullup and receiver control, plus peripheral input return.
// Assumes pin inputs are synchronous to aclk.
`timescale 1ns/100ps
module ppc_pad (
  // Clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // Configuration
  input  wire logic [ppc_pkg::NPINS-1:0] input_mode,
  input  wire logic [ppc_pkg::NPINS-1:0] output_mode,
  input  wire logic [ppc_pkg::NPINS-1:0] latch,
  input  wire logic                      xbar_en,
  input  wire logic                      wpud,
  ppc_map_if.pad                         map,
  // Peripheral side
  input  wire logic [ppc_pkg::NFUNC-1:0] periph_out,
  input  wire logic [ppc_pkg::NFUNC-1:0] periph_oe,
  output logic      [ppc_pkg::NFUNC-1:0] periph_in,
  // Pin side
  input  wire logic [ppc_pkg::NPINS-1:0] pin_i,
  output logic      [ppc_pkg::NPINS-1:0] pin_o,
  output logic      [ppc_pkg::NPINS-1:0] pin_oe,
  output logic      [ppc_pkg::NPINS-1:0] pin_pullup,
  output logic      [ppc_pkg::NPINS-1:0] pin_rx_en,
  output logic      [ppc_pkg::NPINS-1:0] pin_analog_en
);

  logic [ppc_pkg::NPINS-1:0] next_o;       // Level to present
  logic [ppc_pkg::NPINS-1:0] next_oe;      // Driver on
  logic [ppc_pkg::NPINS-1:0] next_pu;      // Weak pullup on
  logic [ppc_pkg::NPINS-1:0] next_rx;      // Digital receiver on
  logic [ppc_pkg::NPINS-1:0] dig_in;       // Gated digital level
  logic [ppc_pkg::NFUNC-1:0] next_pin_in;  // Return to peripherals

  genvar i;
  generate
    for (i = 0; i < ppc_pkg::NPINS; i++) begin : g_pin
      wire [ppc_pkg::FW-1:0] fidx   = map.pin_func[i*ppc_pkg::FW +: ppc_pkg::FW];
      wire                   asg    = map.pin_assigned[i];
      wire                   digital = input_mode[i];
      wire                   is_smb = asg && (fidx == ppc_pkg::PPC_F_SMB_SDA || fidx == ppc_pkg::PPC_F_SMB_SCL);
      wire                   od     = !output_mode[i] || is_smb;
      wire                   val    = asg ? periph_out[fidx] : latch[i];
      wire                   want   = asg ? periph_oe[fidx] : 1'b1;
      // Open-drain only pulls low; push-pull drives both levels
      wire                   drv    = xbar_en && digital && want && (!od || !val);
      assign next_o[i]  = val;
      assign next_oe[i] = drv;
      // Pullup only on open-drain digital pins not holding the line low
      assign next_pu[i] = digital && od && !wpud && !(drv && !val);
      assign next_rx[i] = digital;
      assign dig_in[i]  = digital & pin_i[i];
    end
  endgenerate

  // Route each assigned pin back to its function, idle high when unrouted
  always_comb begin
    next_pin_in = '1;
    for (int p = 0; p < ppc_pkg::NPINS; p++) begin
      if (map.pin_assigned[p]) begin
        next_pin_in[map.pin_func[p*ppc_pkg::FW +: ppc_pkg::FW]] = dig_in[p];
      end
    end
  end

  // Register pad controls; reset leaves every pin a digital input
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_o      <= '1;
      pin_oe     <= '0;
      pin_pullup <= '1;
      pin_rx_en  <= '1;
      periph_in  <= '1;
    end else begin
      pin_o      <= next_o;
      pin_oe     <= next_oe;
      pin_pullup <= next_pu;
      pin_rx_en  <= next_rx;
      periph_in  <= next_pin_in;
    end
  end

  // Analog path stays connected on every pin, digital ones included
  assign pin_analog_en = '1;

endmodule // ppc_pad

// ---- src/ppc_top.sv ----
// Top of the port pin crossbar configuration block: AXI4-Lite register file,
// crossbar decoder and pad control. Assumes one 10 MHz clock, synchronous reset.
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/100ps
module ppc_top (
  // Clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]                s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]                s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // Peripheral side
  input  wire logic [ppc_pkg::NFUNC-1:0] periph_out,
  input  wire logic [ppc_pkg::NFUNC-1:0] periph_oe,
  output logic      [ppc_pkg::NFUNC-1:0] periph_in,
  // Pin side
  input  wire logic [ppc_pkg::NPINS-1:0] pin_i,
  output logic      [ppc_pkg::NPINS-1:0] pin_o,
  output logic      [ppc_pkg::NPINS-1:0] pin_oe,
  output logic      [ppc_pkg::NPINS-1:0] pin_pullup,
  output logic      [ppc_pkg::NPINS-1:0] pin_rx_en,
  output logic      [ppc_pkg::NPINS-1:0] pin_analog_en
);

  // Configuration registers
  logic [15:0] port_input_mode_bits;   // 1 digital, 0 analog
  logic [15:0] port_output_mode_bits;  // 1 push-pull, 0 open-drain
  logic [15:0] crossbar_skip_bits;     // 1 pin skipped by crossbar
  logic [15:0] port_latch;             // General-purpose output levels
  logic [7:0]  crossbar_assign_reg_a;  // Peripheral enables
  logic [7:0]  crossbar_assign_reg_b;  // Crossbar enable and pullup disable

  // Write channel state
  logic [7:0]  aw_addr;                // Held write address
  logic        aw_held;                // Write address taken
  logic [31:0] w_data;                 // Held write data
  logic [3:0]  w_strb;                 // Held byte enables
  logic        w_held;                 // Write data taken

  // Decode wires
  logic        do_write;               // Both halves present, commit now
  logic        wr_hit;                 // Write address is mapped and writable
  logic [15:0] wr_mask;                // Byte enables spread over 16 bits
  logic [15:0] next_input_mode;
  logic [15:0] next_output_mode;
  logic [15:0] next_skip;
  logic [15:0] next_latch;
  logic        rd_hit;                 // Read address is mapped
  logic [31:0] rd_word;                // Selected read value
  logic [7:0]  func_grp;               // Enables from assign register
  logic [ppc_pkg::NFUNC-1:0] func_en;  // Per-function enables
  logic        xbar_en;
  logic        wpud;

  ppc_map_if map ();                   // Pin map between decoder and pads

  // Handshakes: one write and one read in flight
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;

  // Write decode
  assign wr_hit  = (aw_addr == ppc_pkg::OFS_INPUT_MODE)  || (aw_addr == ppc_pkg::OFS_OUTPUT_MODE) ||
                   (aw_addr == ppc_pkg::OFS_SKIP)        || (aw_addr == ppc_pkg::OFS_LATCH) ||
                   (aw_addr == ppc_pkg::OFS_ASSIGN_A)    || (aw_addr == ppc_pkg::OFS_ASSIGN_B);
  assign wr_mask = {{8{w_strb[1]}}, {8{w_strb[0]}}};
  assign next_input_mode  = (port_input_mode_bits  & ~wr_mask) | (w_data[15:0] & wr_mask);
  assign next_output_mode = (port_output_mode_bits & ~wr_mask) | (w_data[15:0] & wr_mask);
  assign next_skip        = (crossbar_skip_bits    & ~wr_mask) | (w_data[15:0] & wr_mask);
  assign next_latch       = (port_latch            & ~wr_mask) | (w_data[15:0] & wr_mask);

  // Read decode; unused upper bits read as zero
  assign rd_hit = (s_axi_araddr == ppc_pkg::OFS_INPUT_MODE) || (s_axi_araddr == ppc_pkg::OFS_OUTPUT_MODE) ||
                  (s_axi_araddr == ppc_pkg::OFS_SKIP)       || (s_axi_araddr == ppc_pkg::OFS_LATCH) ||
                  (s_axi_araddr == ppc_pkg::OFS_ASSIGN_A)   || (s_axi_araddr == ppc_pkg::OFS_ASSIGN_B) ||
                  (s_axi_araddr == ppc_pkg::OFS_PIN_STATE);
  assign rd_word =
    (s_axi_araddr == ppc_pkg::OFS_INPUT_MODE)  ? {16'h0000, port_input_mode_bits}  :
    (s_axi_araddr == ppc_pkg::OFS_OUTPUT_MODE) ? {16'h0000, port_output_mode_bits} :
    (s_axi_araddr == ppc_pkg::OFS_SKIP)        ? {16'h0000, crossbar_skip_bits}    :
    (s_axi_araddr == ppc_pkg::OFS_LATCH)       ? {16'h0000, port_latch}            :
    (s_axi_araddr == ppc_pkg::OFS_ASSIGN_A)    ? {24'h00_0000, crossbar_assign_reg_a} :
    (s_axi_araddr == ppc_pkg::OFS_ASSIGN_B)    ? {24'h00_0000, crossbar_assign_reg_b} :
    (s_axi_araddr == ppc_pkg::OFS_PIN_STATE)   ? {16'h0000, pin_i & port_input_mode_bits} :
    32'h0000_0000;

  // Peripheral group enables spread to functions
  assign func_grp = crossbar_assign_reg_a;
  assign func_en  = {{2{func_grp[ppc_pkg::BIT_SMB_EN]}},
                     {4{func_grp[ppc_pkg::BIT_SPI_EN]}},
                     {2{func_grp[ppc_pkg::BIT_UART_EN]}}};
  assign xbar_en  = crossbar_assign_reg_b[ppc_pkg::BIT_XBAR_EN];
  assign wpud     = crossbar_assign_reg_b[ppc_pkg::BIT_WPUD];

  // Write address capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  // Write data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // Write response, error for unmapped or read-only address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ppc_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? ppc_pkg::RESP_OKAY : ppc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Port mode registers; reset gives all digital inputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_input_mode_bits  <= ppc_pkg::RST_INPUT_MODE;
      port_output_mode_bits <= ppc_pkg::RST_OUTPUT_MODE;
    end else if (do_write && aw_addr == ppc_pkg::OFS_INPUT_MODE) begin
      port_input_mode_bits  <= next_input_mode;
    end else if (do_write && aw_addr == ppc_pkg::OFS_OUTPUT_MODE) begin
      port_output_mode_bits <= next_output_mode;
    end
  end

  // Skip and latch registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crossbar_skip_bits <= ppc_pkg::RST_SKIP;
      port_latch         <= ppc_pkg::RST_LATCH;
    end else if (do_write && aw_addr == ppc_pkg::OFS_SKIP) begin
      crossbar_skip_bits <= next_skip;
    end else if (do_write && aw_addr == ppc_pkg::OFS_LATCH) begin
      port_latch         <= next_latch;
    end
  end

  // Crossbar assignment registers, low byte lane only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crossbar_assign_reg_a <= ppc_pkg::RST_ASSIGN_A;
      crossbar_assign_reg_b <= ppc_pkg::RST_ASSIGN_B;
    end else if (do_write && w_strb[0] && aw_addr == ppc_pkg::OFS_ASSIGN_A) begin
      crossbar_assign_reg_a <= w_data[7:0];
    end else if (do_write && w_strb[0] && aw_addr == ppc_pkg::OFS_ASSIGN_B) begin
      crossbar_assign_reg_b <= w_data[7:0];
    end
  end

  // Read channel, answer one cycle after address taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= ppc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? ppc_pkg::RESP_OKAY : ppc_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Crossbar priority decoder
  ppc_xbar u_xbar (
    .func_en (func_en),
    .skip    (crossbar_skip_bits),
    .xbar_en (xbar_en),
    .map     (map)
  );

  // Pad control
  ppc_pad u_pad (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .input_mode    (port_input_mode_bits),
    .output_mode   (port_output_mode_bits),
    .latch         (port_latch),
    .xbar_en       (xbar_en),
    .wpud          (wpud),
    .map           (map),
    .periph_out    (periph_out),
    .periph_oe     (periph_oe),
    .periph_in     (periph_in),
    .pin_i         (pin_i),
    .pin_o         (pin_o),
    .pin_oe        (pin_oe),
    .pin_pullup    (pin_pullup),
    .pin_rx_en     (pin_rx_en),
    .pin_analog_en (pin_analog_en)
  );

endmodule // ppc_top

// ---- tb/ppc_top_checker.sv ----
// Concurrent checks on the ports of the port pin crossbar top.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/100ps
module ppc_top_checker (
  // Clock and reset
  input wire logic                      aclk,
  input wire logic                      aresetn,
  // Register bus handshakes
  input wire logic                      s_axi_awvalid,
  input wire logic                      s_axi_awready,
  input wire logic                      s_axi_wvalid,
  input wire logic                      s_axi_wready,
  input wire logic [1:0]                s_axi_bresp,
  input wire logic                      s_axi_bvalid,
  input wire logic                      s_axi_bready,
  input wire logic                      s_axi_arvalid,
  input wire logic                      s_axi_arready,
  input wire logic [31:0]               s_axi_rdata,
  input wire logic                      s_axi_rvalid,
  input wire logic                      s_axi_rready,
  // Pad controls
  input wire logic [ppc_pkg::NPINS-1:0] pin_o,
  input wire logic [ppc_pkg::NPINS-1:0] pin_oe,
  input wire logic [ppc_pkg::NPINS-1:0] pin_pullup,
  input wire logic [ppc_pkg::NPINS-1:0] pin_rx_en,
  input wire logic [ppc_pkg::NPINS-1:0] pin_analog_en
);
  // All checks share the system clock and its reset
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_analog_quiet: assert property ((~pin_rx_en & (pin_oe | pin_pullup)) == 16'h0000)
    else $error("analog pin keeps its driver or pullup");
  a_reset_inputs: assert property (!$past(aresetn) |-> pin_oe == 16'h0000 && pin_rx_en == 16'hFFFF)
    else $error("pins not digital inputs after reset");
  a_pullup_low_off: assert property ((pin_oe & ~pin_o & pin_pullup) == 16'h0000)
    else $error("pullup on while pin drives low");
  a_analog_path: assert property (pin_analog_en == 16'hFFFF)
    else $error("analog path closed on a pin");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
endmodule // ppc_top_checker

bind ppc_top ppc_top_checker chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .pin_o, .pin_oe, .pin_pullup, .pin_rx_en, .pin_analog_en);

// ---- tb/ppc_pin_model.sv ----
// Board side of the pads: resolves each pin from the block's driver, an external driver and the pullup.
// Assumes external drive is set by the bench; a floating pin toggles so no stale level survives.
`timescale 1ns/100ps
module ppc_pin_model (
  // Clock
  input  wire logic                      aclk,
  // Block pad controls
  input  wire logic [ppc_pkg::NPINS-1:0] pin_o,
  input  wire logic [ppc_pkg::NPINS-1:0] pin_oe,
  input  wire logic [ppc_pkg::NPINS-1:0] pin_pullup,
  // External drivers
  input  wire logic [ppc_pkg::NPINS-1:0] ext_drive,
  input  wire logic [ppc_pkg::NPINS-1:0] ext_level,
  // Resolved levels
  output logic      [ppc_pkg::NPINS-1:0] pin_i
);
  logic float_lvl = 1'b0; // Changes every cycle on undriven pins

  // Floating pattern
  always_ff @(posedge aclk) begin
    float_lvl <= ~float_lvl;
  end

  // Block driver wins, then external, then pullup, else floating
  always_comb begin
    for (int p = 0; p < ppc_pkg::NPINS; p++) begin
      pin_i[p] = pin_oe[p] ? pin_o[p] : ext_drive[p] ? ext_level[p] : pin_pullup[p] ? 1'b1 : float_lvl;
    end
  end
endmodule // ppc_pin_model

// ---- tb/tb_port_pin_crossbar_config.sv ----
// Self-checking bench: AXI4-Lite register tasks, pin checks against the board model.
// Assumes a 10 MHz clock and the register map of the package.
`timescale 1ns/100ps
module tb_port_pin_crossbar_config;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0]  awaddr = 0, araddr = 0, periph_out = 0, periph_oe = 0;
  logic [31:0] wdata = 0, rd;
  logic [3:0]  wstrb = 0;
  logic [15:0] ext_drive = 0, ext_level = 0;
  wire  [31:0] rdata;
  wire  [15:0] pin_i, pin_o, pin_oe, pin_pu, pin_rx;
  wire  [7:0]  periph_in;
  wire  [1:0]  bresp, rresp;
  wire         awready, wready, bvalid, arready, rvalid;
  int          err_total = 0, checked = 0;

  // System clock, 100 ns period
  always #50 aclk = ~aclk;

  ppc_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .periph_out(periph_out),
    .periph_oe(periph_oe), .periph_in(periph_in), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
    .pin_pullup(pin_pu), .pin_rx_en(pin_rx), .pin_analog_en());
  ppc_pin_model pads (.aclk(aclk), .pin_o(pin_o), .pin_oe(pin_oe), .pin_pullup(pin_pu),
    .ext_drive(ext_drive), .ext_level(ext_level), .pin_i(pin_i));

  // Compare and count
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Reset held for eight cycles
  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  // One write; each channel released when taken, bready stays high between writes
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a; wdata <= d; wstrb <= 4'hF; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    check("bresp", {30'h0, bresp}, {30'h0, er});
  endtask

  // One read; data taken at the rvalid edge, rready stays high between reads
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    d = rdata;
    check("rresp", {30'h0, rresp}, {30'h0, er});
  endtask

  // Watchdog
  initial begin
    #500000;
    err_total++;
    results();
  end

  initial begin
    logic [7:0]  ofs [6];
    logic [31:0] rv [6];
    ofs = '{ppc_pkg::OFS_INPUT_MODE, ppc_pkg::OFS_OUTPUT_MODE, ppc_pkg::OFS_SKIP, ppc_pkg::OFS_LATCH,
            ppc_pkg::OFS_ASSIGN_A, ppc_pkg::OFS_ASSIGN_B};
    rv  = '{{16'h0, ppc_pkg::RST_INPUT_MODE}, {16'h0, ppc_pkg::RST_OUTPUT_MODE}, {16'h0, ppc_pkg::RST_SKIP},
            {16'h0, ppc_pkg::RST_LATCH}, {24'h0, ppc_pkg::RST_ASSIGN_A}, {24'h0, ppc_pkg::RST_ASSIGN_B}};
    // Reset values, unmapped and read-only places
    do_reset();
    for (int i = 0; i < 6; i++) begin
      axi_read(ofs[i], rd, ppc_pkg::RESP_OKAY);
      check("reset value", rd, rv[i]);
    end
    check("rx after reset", {16'h0, pin_rx}, 32'h0000_FFFF);
    axi_read(8'h1C, rd, ppc_pkg::RESP_SLVERR);
    check("unmapped read", rd, 32'h0000_0000);
    axi_write(ppc_pkg::OFS_PIN_STATE, 32'h0000_0000, ppc_pkg::RESP_SLVERR);
    $display("test registers done");

    // General outputs, pullups and the pullup disable
    do_reset();
    axi_write(ppc_pkg::OFS_OUTPUT_MODE, 32'h0000_00FF, ppc_pkg::RESP_OKAY);
    axi_write(ppc_pkg::OFS_LATCH, 32'h0000_0F0F, ppc_pkg::RESP_OKAY);
    repeat (3) @(posedge aclk);
    check("oe crossbar off", {16'h0, pin_oe}, 32'h0000_0000);
    axi_write(ppc_pkg::OFS_ASSIGN_B, 32'h0000_0040, ppc_pkg::RESP_OKAY);
    repeat (3) @(posedge aclk);
    check("oe gpio", {16'h0, pin_oe}, 32'h0000_F0FF);
    check("o gpio", {16'h0, pin_o & pin_oe}, 32'h0000_000F);
    check("pullup", {16'h0, pin_pu}, 32'h0000_0F00);
    axi_write(ppc_pkg::OFS_ASSIGN_B, 32'h0000_00C0, ppc_pkg::RESP_OKAY);
    repeat (3) @(posedge aclk);
    check("pullup disabled", {16'h0, pin_pu}, 32'h0000_0000);
    check("push-pull kept", {16'h0, pin_oe}, 32'h0000_F0FF);
    axi_read(ppc_pkg::OFS_ASSIGN_B, rd, ppc_pkg::RESP_OKAY);
    check("assign b", rd, 32'h0000_00C0);
    $display("test gpio done");

    // Analog pins 0 and 2 skipped, UART and two-wire routed, in the set-up order
    do_reset();
    periph_out <= 8'h41;
    periph_oe  <= 8'hC1;
    ext_drive  <= 16'h0008;
    axi_write(ppc_pkg::OFS_INPUT_MODE, 32'h0000_FFFA, ppc_pkg::RESP_OKAY);
    axi_write(ppc_pkg::OFS_LATCH, 32'h0000_FFFF, ppc_pkg::RESP_OKAY);
    axi_write(ppc_pkg::OFS_OUTPUT_MODE, 32'h0000_FFFF, ppc_pkg::RESP_OKAY);
    axi_write(ppc_pkg::OFS_SKIP, 32'h0000_0005, ppc_pkg::RESP_OKAY);
    axi_write(ppc_pkg::OFS_ASSIGN_A, 32'h0000_0005, ppc_pkg::RESP_OKAY);
    repeat (3) @(posedge aclk);
    check("oe crossbar off", {16'h0, pin_oe}, 32'h0000_0000);
    axi_write(ppc_pkg::OFS_ASSIGN_B, 32'h0000_0040, ppc_pkg::RESP_OKAY);
    repeat (3) @(posedge aclk);
    check("analog rx", {16'h0, pin_rx & 16'h0005}, 32'h0000_0000);
    check("analog oe", {16'h0, (pin_oe | pin_pu) & 16'h0005}, 32'h0000_0000);
    check("routed oe", {16'h0, pin_oe & 16'h007A}, 32'h0000_0062);
    check("routed o", {16'h0, pin_o & 16'h0062}, 32'h0000_0042);
    check("rx from pin 3", {31'h0, periph_in[1]}, 32'h0000_0000);
    check("scl return", {31'h0, periph_in[7]}, 32'h0000_0000);
    check("unrouted in", {31'h0, periph_in[2]}, 32'h0000_0001);
    ext_level <= 16'h0008;
    repeat (3) @(posedge aclk);
    check("rx follows pin", {31'h0, periph_in[1]}, 32'h0000_0001);
    axi_read(ppc_pkg::OFS_PIN_STATE, rd, ppc_pkg::RESP_OKAY);
    check("analog state", rd & 32'h0000_0005, 32'h0000_0000);
    $display("test crossbar done");
    results();
  end
endmodule // tb_port_pin_crossbar_config
